// *** rtl/epo_pkg.sv ***
package epo_pkg;
    // clock and time base
    localparam int CLK_MHZ = 125;
    localparam int WD_PULSE_US = 16000;
    localparam int WD_PERIOD_US = 1600000;
    localparam int STEP_SHORT_US = 31250;
    localparam int STEP_LONG_US = 156250;
    localparam int WD_PULSE_CYC = WD_PULSE_US * CLK_MHZ;
    localparam int WD_PERIOD_CYC = WD_PERIOD_US * CLK_MHZ;
    localparam int STEP_SHORT_CYC = STEP_SHORT_US * CLK_MHZ;
    localparam int STEP_LONG_CYC = STEP_LONG_US * CLK_MHZ;
    localparam int WD_CNT_W = 28;
    localparam int STEP_CNT_W = 25;

    // energy path
    localparam int POWER_W = 8;
    localparam int ACC_W = 20;
    localparam logic signed [19:0] THR_FULL = 20'sh00400;
    localparam logic signed [19:0] THR_HALF = 20'sh00200;
    localparam logic [2:0] TOPO_DOUBLE = 3'h3;

    // negative power modes
    localparam logic [1:0] NEG_FERRARIS = 2'h0;
    localparam logic [1:0] NEG_ABS = 2'h1;
    localparam logic [1:0] NEG_FERR_PHASE = 2'h2;
    localparam logic [1:0] NEG_SIGNED = 2'h3;

    localparam logic [1:0] MODE_PERIPH = 2'h0;

    // stepper divisor, index [pulse_length_select][output_rate_select]
    localparam logic [11:0] CM_DIV [2][4] = '{
        '{12'h040, 12'h080, 12'h020, 12'h100},
        '{12'h280, 12'h500, 12'h140, 12'ha00}};

    typedef enum logic [2:0] {
        WD_HOLD = 3'b001,
        WD_COUNT = 3'b010,
        WD_PULSE = 3'b100
    } epo_wd_t;
endpackage

// *** rtl/epo_energy_pulse_output.sv ***
`timescale 1ns/1ps
// How it works
// - active, reactive, fundamental powers integrate into 20-bit accumulators; sign mode applies to active ones only, reactive always signed
// - each accumulator emits pulses at energy rate; any one reaches the pulse pin
// - wideband active energy: one pulse per 2^10 LSB, any topology
// - other energies: 2^10 LSB per pulse, 2^9 for topology 3
// - integration of averaged power keeps pulse rate free of line ripple
// - pulse pin delivers calibrated meter constant pulses per kWh
// - upper mode bit zero means serial pins serve host access only
// - mode 0: positive motor pin carries zero crossing
// - mode 0: negative motor pin carries 16 ms watchdog pulse every 1.6 s
// - watchdog output high while supply low, runs once supply recovers
// - each latch request while counting restarts watchdog, none during its pulse; 1.6 s silence gives a pulse
// - modes 0 and 1: length and fundamental selects choose energy on pulse pin
// - mode 0: rate select picks three-phase sum or phase R, S, T
// - mode 1: motor pins drive stepper from three-phase active energy
// - mode 1: pulse pin shows three-phase energy, rate select ignored
// - stepper pulse 31.25 or 156.25 ms, alternating between coils
// - no-load holds both motor pins low in stepper modes (not mode 0), integration suspended
// - negative mode: signed Ferraris, absolute, per-phase Ferraris, signed
module epo_energy_pulse_output
    import epo_pkg::*;
#(
    parameter int unsigned WD_PULSE_CYCLES = WD_PULSE_CYC,
    parameter int unsigned WD_PERIOD_CYCLES = WD_PERIOD_CYC,
    parameter int unsigned STEP_SHORT_CYCLES = STEP_SHORT_CYC,
    parameter int unsigned STEP_LONG_CYCLES = STEP_LONG_CYC
) (
    input wire logic clk_in,
    input wire logic reset_n_in,
    input wire logic [1:0] application_mode_select_in,
    input wire logic [1:0] output_rate_select_in,
    input wire logic pulse_length_select_in,
    input wire logic harmonic_only_select_in,
    input wire logic [1:0] negative_power_mode_in,
    input wire logic [2:0] network_topology_in,
    input wire logic power_valid_in,
    input wire logic [2:0][7:0] active_power_in,
    input wire logic [2:0][7:0] fund_active_power_in,
    input wire logic [2:0][7:0] reactive_power_in,
    input wire logic [2:0][7:0] fund_reactive_power_in,
    input wire logic no_load_flag_in,
    input wire logic zero_crossing_signal_in,
    input wire logic latch_strobe_pin_in,
    input wire logic supply_low_in,
    output logic energy_pulse_out,
    output logic motor_out_pos_out,
    output logic motor_out_neg_out,
    output logic serial_comm_only_out
);
    logic rst_meta, rst_n;
    always_ff @(posedge clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            rst_meta <= 1'b0;
            rst_n <= 1'b0;
        end else begin
            rst_meta <= 1'b1;
            rst_n <= rst_meta;
        end
    end

    // pins: latch, zero crossing, supply monitor
    logic [2:0] sync1, sync2;
    logic latch_prev;
    always_ff @(posedge clk_in or negedge rst_n) begin
        if (!rst_n) begin
            sync1 <= 3'h0;
            sync2 <= 3'h0;
            latch_prev <= 1'b0;
        end else begin
            sync1 <= {supply_low_in, zero_crossing_signal_in, latch_strobe_pin_in};
            sync2 <= sync1;
            latch_prev <= sync2[0];
        end
    end
    logic latch_rise, zcr_sync, supply_low;
    assign latch_rise = sync2[0] & ~latch_prev;
    assign zcr_sync = sync2[1];
    assign supply_low = sync2[2];

    function automatic logic signed [19:0] phase_term(input logic [7:0] p,
            input logic active, input logic [1:0] mode);
        logic signed [19:0] x;
        x = {{12{p[7]}}, p};
        if (active && mode == NEG_ABS && x < 0)
            x = -x;
        if (active && mode == NEG_FERR_PHASE && x < 0)
            x = 20'sh0;
        return x;
    endfunction

    // accumulators: index {energy, source}, energy P F Q R, source sum R S T
    logic signed [19:0] acc [16];
    logic signed [19:0] next_acc [16];
    logic [15:0] pulse_q, next_pulse;
    logic p_neg, next_p_neg;
    logic [7:0] pw [4][3];
    logic integrate;
    assign integrate = power_valid_in & ~no_load_flag_in;

    always_comb begin
        logic signed [19:0] val, thr, na;
        logic active;
        int e, s;
        val = 20'sh0;
        thr = THR_FULL;
        na = 20'sh0;
        active = 1'b0;
        e = 0;
        s = 0;
        for (int k = 0; k < 3; k++) begin
            pw[0][k] = active_power_in[k];
            pw[1][k] = fund_active_power_in[k];
            pw[2][k] = reactive_power_in[k];
            pw[3][k] = fund_reactive_power_in[k];
        end
        next_p_neg = p_neg;
        for (int i = 0; i < 16; i++) begin
            e = i / 4;
            s = i % 4;
            active = (e < 2);
            if (s == 0)
                val = phase_term(pw[e][0], active, negative_power_mode_in)
                    + phase_term(pw[e][1], active, negative_power_mode_in)
                    + phase_term(pw[e][2], active, negative_power_mode_in);
            else
                val = phase_term(pw[e][s-1], active, negative_power_mode_in);
            if (i == 0 && integrate)
                next_p_neg = (val < 0);
            thr = (e != 0 && network_topology_in == TOPO_DOUBLE) ? THR_HALF : THR_FULL;
            na = acc[i] + (integrate ? val : 20'sh0);
            next_pulse[i] = 1'b0;
            // one pulse per meter constant quantum
            if (na >= thr) begin
                na = na - thr;
                next_pulse[i] = 1'b1;
            end else if (na <= -thr) begin
                // ferraris modes stall instead of counting back
                if (e >= 2 || negative_power_mode_in == NEG_SIGNED) begin
                    na = na + thr;
                    next_pulse[i] = 1'b1;
                end else begin
                    na = -thr;
                end
            end
            next_acc[i] = na;
        end
    end

    always_ff @(posedge clk_in or negedge rst_n) begin
        if (!rst_n) begin
            for (int i = 0; i < 16; i++)
                acc[i] <= 20'sh0;
            pulse_q <= 16'h0;
            p_neg <= 1'b0;
        end else begin
            for (int i = 0; i < 16; i++)
                acc[i] <= next_acc[i];
            pulse_q <= next_pulse;
            p_neg <= next_p_neg;
        end
    end

    // pulse pin source
    logic [3:0] sel_idx;
    logic periph;
    assign periph = (application_mode_select_in == MODE_PERIPH);
    // energy from selects below mode 2, phase only in mode 0
    assign sel_idx = {application_mode_select_in[1] ? 2'h0
        : {pulse_length_select_in, harmonic_only_select_in},
        periph ? output_rate_select_in : 2'h0};

    // watchdog
    epo_wd_t wd_state, next_wd_state;
    logic [27:0] wd_cnt, next_wd_cnt;
    always_comb begin
        next_wd_state = wd_state;
        next_wd_cnt = wd_cnt + 28'h1;
        unique case (wd_state)
            WD_HOLD: begin
                next_wd_cnt = 28'h0;
                next_wd_state = WD_COUNT;
            end
            WD_COUNT: begin
                if (latch_rise) begin
                    next_wd_cnt = 28'h0;
                end else if (wd_cnt >= 28'(WD_PERIOD_CYCLES - 1)) begin
                    next_wd_cnt = 28'h0;
                    next_wd_state = WD_PULSE;
                end
            end
            WD_PULSE: begin
                if (wd_cnt >= 28'(WD_PULSE_CYCLES - 1)) begin
                    next_wd_cnt = 28'h0;
                    next_wd_state = WD_COUNT;
                end
            end
            default: begin
                next_wd_cnt = 28'h0;
                next_wd_state = WD_HOLD;
            end
        endcase
        if (supply_low) begin
            next_wd_cnt = 28'h0;
            next_wd_state = WD_HOLD;
        end
    end

    // stepper: divider, mono-flop, coil decoder
    logic [11:0] step_div, next_step_div;
    logic [24:0] step_cnt, next_step_cnt;
    logic step_on, next_step_on, coil, next_coil;
    always_comb begin
        next_step_div = step_div;
        next_step_cnt = step_cnt;
        next_step_on = step_on;
        next_coil = coil;
        if (step_on) begin
            next_step_cnt = step_cnt + 25'h1;
            if (step_cnt >= 25'(pulse_length_select_in ? STEP_LONG_CYCLES - 1
                    : STEP_SHORT_CYCLES - 1))
                next_step_on = 1'b0;
        end
        if (!periph && pulse_q[0]) begin
            if (step_div >= CM_DIV[pulse_length_select_in][output_rate_select_in] - 12'h1) begin
                next_step_div = 12'h0;
                // a retrigger inside a running pulse is dropped
                if (!step_on) begin
                    next_step_on = 1'b1;
                    next_step_cnt = 25'h0;
                    next_coil = ~coil;
                end
            end else begin
                next_step_div = step_div + 12'h1;
            end
        end
    end

    logic next_pos, next_neg, step_hold;
    always_comb begin
        // no-load or negative ferraris sum stops the motor
        step_hold = no_load_flag_in | (negative_power_mode_in == NEG_FERRARIS & p_neg);
        if (periph) begin
            // zero crossing and watchdog on motor pins
            next_pos = zcr_sync;
            next_neg = (next_wd_state != WD_COUNT);
        end else begin
            next_pos = step_on & coil & ~step_hold;
            next_neg = step_on & ~coil & ~step_hold;
        end
    end

    always_ff @(posedge clk_in or negedge rst_n) begin
        if (!rst_n) begin
            wd_state <= WD_HOLD;
            wd_cnt <= 28'h0;
            step_div <= 12'h0;
            step_cnt <= 25'h0;
            step_on <= 1'b0;
            coil <= 1'b0;
            energy_pulse_out <= 1'b0;
            motor_out_pos_out <= 1'b0;
            motor_out_neg_out <= 1'b1;
            serial_comm_only_out <= 1'b1;
        end else begin
            wd_state <= next_wd_state;
            wd_cnt <= next_wd_cnt;
            step_div <= next_step_div;
            step_cnt <= next_step_cnt;
            step_on <= next_step_on;
            coil <= next_coil;
            energy_pulse_out <= pulse_q[sel_idx];
            motor_out_pos_out <= next_pos;
            motor_out_neg_out <= next_neg;
            // serial pins for host access only
            serial_comm_only_out <= ~application_mode_select_in[1];
        end
    end

    supply_hold_a: assert property (@(posedge clk_in) disable iff (!rst_n)
        supply_low && periph ##1 periph |-> motor_out_neg_out)
        else $error("watchdog not high at low supply");
    wd_restart_a: assert property (@(posedge clk_in) disable iff (!rst_n)
        wd_state == WD_COUNT && latch_rise && !supply_low |=> wd_cnt == 28'h0)
        else $error("latch did not restart watchdog");
    wd_width_a: assert property (@(posedge clk_in) disable iff (!rst_n)
        wd_state == WD_PULSE |-> wd_cnt < 28'(WD_PULSE_CYCLES))
        else $error("watchdog pulse too long");
    wd_period_a: assert property (@(posedge clk_in) disable iff (!rst_n)
        wd_state == WD_COUNT |-> wd_cnt < 28'(WD_PERIOD_CYCLES))
        else $error("watchdog interval overrun");
    zcr_route_a: assert property (@(posedge clk_in) disable iff (!rst_n)
        periph |=> motor_out_pos_out == $past(zcr_sync))
        else $error("zero crossing not on positive motor pin");
    no_load_low_a: assert property (@(posedge clk_in) disable iff (!rst_n)
        !periph && no_load_flag_in |=> !motor_out_pos_out && !motor_out_neg_out)
        else $error("motor pins driven at no load");
    coil_swap_a: assert property (@(posedge clk_in) disable iff (!rst_n)
        $rose(step_on) |-> coil != $past(coil))
        else $error("stepper coils did not alternate");
    acc_bound_a: assert property (@(posedge clk_in) disable iff (!rst_n)
        acc[0] < THR_FULL && acc[0] >= -THR_FULL)
        else $error("active accumulator out of range");
    led_route_a: assert property (@(posedge clk_in) disable iff (!rst_n)
        application_mode_select_in == 2'h1 |=> energy_pulse_out
            == $past(pulse_q[{pulse_length_select_in, harmonic_only_select_in, 2'h0}]))
        else $error("pulse pin not on three-phase energy");
endmodule

// *** testbench/epo_host_model.sv ***
`timescale 1ns/1ps
module epo_host_model (
    input wire logic clk_in,
    input wire logic enable_in,
    input wire logic [7:0] period_in,
    output logic latch_strobe_pin_out
);
    logic [7:0] count;

    always @(posedge clk_in) begin
        if (!enable_in) begin
            count <= 8'h00;
            latch_strobe_pin_out <= 1'b0;
        end else begin
            count <= (count == period_in) ? 8'h00 : count + 8'h01;
            // two cycles high, so the synchroniser cannot miss it
            latch_strobe_pin_out <= (count < 8'h02);
        end
    end
endmodule

// *** testbench/epo_energy_pulse_output_tb.sv ***
`timescale 1ns/1ps
module epo_energy_pulse_output_tb;
    localparam int WD_P = 8;
    localparam int WD_T = 64;
    localparam int ST_S = 16;
    localparam int ST_L = 40;
    localparam int N = 128;
    logic clk_in = 1'b0;
    logic reset_n_in = 1'b0;
    logic [1:0] app_mode = 2'h0;
    logic [1:0] rate_sel = 2'h0;
    logic len_sel = 1'b0;
    logic fund_sel = 1'b0;
    logic [1:0] neg_mode = 2'h0;
    logic [2:0] topo = 3'h0;
    logic valid = 1'b0;
    logic [3:0][2:0][7:0] pw = '0;
    logic no_load = 1'b0;
    logic zc = 1'b0;
    logic supply_low = 1'b0;
    logic host_en = 1'b0;
    logic latch, ep, pos, neg, sco, pos_q, neg_q;
    int miscompares = 0;
    int compares = 0;
    int cycles = 0;
    int ep_cnt, pos_cnt, neg_cnt, run, hi_w;

    epo_energy_pulse_output #(
        .WD_PULSE_CYCLES(WD_P),
        .WD_PERIOD_CYCLES(WD_T),
        .STEP_SHORT_CYCLES(ST_S),
        .STEP_LONG_CYCLES(ST_L)
    ) dut_u (
        .clk_in(clk_in),
        .reset_n_in(reset_n_in),
        .application_mode_select_in(app_mode),
        .output_rate_select_in(rate_sel),
        .pulse_length_select_in(len_sel),
        .harmonic_only_select_in(fund_sel),
        .negative_power_mode_in(neg_mode),
        .network_topology_in(topo),
        .power_valid_in(valid),
        .active_power_in(pw[0]),
        .fund_active_power_in(pw[1]),
        .reactive_power_in(pw[2]),
        .fund_reactive_power_in(pw[3]),
        .no_load_flag_in(no_load),
        .zero_crossing_signal_in(zc),
        .latch_strobe_pin_in(latch),
        .supply_low_in(supply_low),
        .energy_pulse_out(ep),
        .motor_out_pos_out(pos),
        .motor_out_neg_out(neg),
        .serial_comm_only_out(sco)
    );

    epo_host_model host_u (
        .clk_in(clk_in),
        .enable_in(host_en),
        .period_in(8'h14),
        .latch_strobe_pin_out(latch)
    );

    initial begin
        forever #4 clk_in = ~clk_in;
    end

    task automatic end_sim();
        $display("compares %0d miscompares %0d", compares, miscompares);
        if (miscompares == 0 && compares > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask

    always @(negedge clk_in) begin
        cycles++;
        if (cycles == 30000) begin
            miscompares++;
            $display("ERROR %0t: timeout", $time);
            end_sim();
        end
    end

    // outputs are settled at the falling edge
    always @(negedge clk_in) begin
        if (ep === 1'b1) ep_cnt++;
        if (pos === 1'b1 && pos_q !== 1'b1) pos_cnt++;
        if (neg === 1'b1 && neg_q !== 1'b1) neg_cnt++;
        if (pos === 1'b1 || neg === 1'b1) run++;
        else begin
            if (run > hi_w) hi_w = run;
            run = 0;
        end
        pos_q = pos;
        neg_q = neg;
    end

    task automatic chk(input int got, input int lo, input int hi);
        compares++;
        if (got < lo || got > hi) begin
            miscompares++;
            $display("ERROR %0t: got %0d, expected %0d..%0d", $time, got, lo, hi);
        end
    endtask

    task automatic chkb(input logic got, input logic exp);
        compares++;
        if (got !== exp) begin
            miscompares++;
            $display("ERROR %0t: pin %b, expected %b", $time, got, exp);
        end
    endtask

    task automatic do_reset();
        @(negedge clk_in);
        reset_n_in = 1'b0;
        repeat (16) @(negedge clk_in);
        chkb(ep, 1'b0);
        chkb(neg, 1'b1);
        reset_n_in = 1'b1;
        repeat (3) @(negedge clk_in);
    endtask

    // cleared at the rising edge so the monitor never races it
    task automatic feed(input int n, input int tail);
        @(posedge clk_in);
        ep_cnt = 0;
        pos_cnt = 0;
        neg_cnt = 0;
        hi_w = 0;
        @(negedge clk_in);
        valid = 1'b1;
        repeat (n) @(negedge clk_in);
        valid = 1'b0;
        repeat (tail) @(negedge clk_in);
    endtask

    task automatic set_pw(input int sgn);
        for (int k = 0; k < 4; k++)
            for (int p = 0; p < 3; p++)
                pw[k][p] = 8'(sgn * (16 * (k + 1) + 4 * p));
    endtask

    task automatic wait_neg(input logic lvl, input int mx, output int c);
        c = 0;
        while (neg !== lvl && c < mx) begin
            @(negedge clk_in);
            c++;
        end
    endtask

    function automatic int exp_ep(int sel, int rate, int mode, int tp);
        int s = 0;
        for (int p = 0; p < 3; p++)
            if (mode != 0 || rate == 0 || rate == p + 1) s += 16 * (sel + 1) + 4 * p;
        return (N * s) / ((tp == 3 && sel != 0) ? 512 : 1024);
    endfunction

    initial begin
        int c;
        int e;
        int n;
        // every energy and phase, topologies 0 and 3, both pulse pin modes
        for (int i = 0; i < 64; i++) begin
            app_mode = 2'(i[5]);
            {len_sel, fund_sel} = i[3:2];
            rate_sel = i[1:0];
            neg_mode = i[1:0];
            topo = i[4] ? 3'h3 : 3'h0;
            set_pw(1);
            do_reset();
            feed(N, 6);
            e = exp_ep(i[3:2], i[1:0], i[5], topo);
            chk(ep_cnt, e, e);
            chkb(sco, 1'b1);
        end
        // negative power: saturating sum against absolute per phase
        {app_mode, len_sel, fund_sel, rate_sel, topo} = '0;
        for (int m = 0; m < 2; m++) begin
            neg_mode = 2'(m);
            set_pw(-1);
            do_reset();
            feed(N, 6);
            chk(ep_cnt, 7 * m, 7 * m);
        end
        set_pw(1);
        do_reset();
        wait_neg(1'b0, 8, c);
        chk(c, 0, 4);
        wait_neg(1'b1, 200, c);
        chk(c, WD_T, WD_T + 3);
        wait_neg(1'b0, 200, c);
        chk(c, WD_P, WD_P);
        host_en = 1'b1;
        wait_neg(1'b1, 300, c);
        chk(c, 300, 300);
        zc = 1'b1;
        repeat (6) @(negedge clk_in);
        chkb(pos, 1'b1);
        zc = 1'b0;
        repeat (6) @(negedge clk_in);
        chkb(pos, 1'b0);
        host_en = 1'b0;
        supply_low = 1'b1;
        repeat (6) @(negedge clk_in);
        wait_neg(1'b0, 100, c);
        chk(c, 100, 100);
        supply_low = 1'b0;
        wait_neg(1'b0, 10, c);
        chk(c, 0, 7);
        // stepper, short and long pulse, coils alternating
        rate_sel = 2'h2;
        for (int l = 0; l < 2; l++) begin
            app_mode = 2'(l + 1);
            len_sel = l[0];
            pw[0] = {3{8'h64}};
            do_reset();
            n = l ? 1100 : 700;
            feed(n, 60);
            e = (n * 300 / 1024) / (l ? 320 : 32);
            chk(pos_cnt, (e + 1) / 2, (e + 1) / 2);
            chk(neg_cnt, e / 2, e / 2);
            chk(hi_w, l ? ST_L : ST_S, (l ? ST_L : ST_S) + 1);
            chkb(sco, l ? 1'b0 : 1'b1);
        end
        // no load, then negative sum under the saturating mode
        {app_mode, len_sel, neg_mode} = {2'h1, 1'b0, 2'h0};
        for (int j = 0; j < 2; j++) begin
            no_load = 1'b0;
            pw[0] = {3{8'h64}};
            do_reset();
            valid = 1'b1;
            c = 0;
            while (pos !== 1'b1 && c < 200) begin
                @(negedge clk_in);
                c++;
            end
            chk(c, 112, 112);
            // cut a running coil pulse
            if (j)
                pw[0] = {3{8'h9c}};
            else
                no_load = 1'b1;
            repeat (2) @(negedge clk_in);
            chkb(pos | neg, 1'b0);
            feed(700, 20);
            chk(pos_cnt + neg_cnt + ep_cnt, 0, 0);
        end
        end_sim();
    end
endmodule
